// File: rtl/bridge_cmd_pkg.sv
// Purpose: constants for the bridge command/status register pair
// Assumes: registers are word aligned at four times their index
// Notes: all offsets, field positions and reset values live here
package bridge_cmd_pkg;
  // register indices; byte address is index * 4
  localparam logic [7:0] CMD_IDX = 8'h04;
  localparam logic [7:0] STS_IDX = 8'h06;
  localparam logic [7:0] IRQ_STAT_IDX = 8'h20;
  localparam logic [7:0] IRQ_MASK_IDX = 8'h21;
  // command fields
  localparam int CMD_IO_BIT = 0;
  localparam int CMD_MEM_BIT = 1;
  localparam int CMD_BM_BIT = 2;
  localparam int CMD_ERRMSG_BIT = 8;
  localparam logic [15:0] CMD_RESET = 16'h0000;
  // bits that must read zero in the command register
  localparam logic [15:0] CMD_ZERO_MASK = 16'hFEF8;
  // status fields
  localparam int STS_SSE_BIT = 14;
  localparam logic [15:0] STS_RESET = 16'h00A0;
  localparam logic [15:0] STS_CONST_MASK = 16'hBFFF;
  // interrupt status / mask layout
  localparam int IRQ_W = 2;
  localparam int IRQ_MSG_BIT = 0;
  localparam int IRQ_ABORT_BIT = 1;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;
  // bus encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HRESP_OKAY = 2'h0;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_READ = 1'b1
  } bus_state_t;
endpackage : bridge_cmd_pkg

// File: rtl/agp_bridge_command_status.sv
// Purpose: command/status register pair of a virtual bridge, AHB-Lite slave
// Assumes: all non-bus inputs come from logic on clk
// Notes: reads take one wait state, writes none
//
// What this block does
// - command register resets to zero; all decode, mastering and messaging off.
// - back-to-back, stepping, parity-check and special-cycle bits read zero.
// - write-invalidate enable bit reads zero whatever is written.
// - error message enable gates every system-error message of this function.
// - bus-master enable low makes AGP frame cycles master abort.
// - enable high accepts decoded frame cycles; sideband and pipe unaffected.
// - memory enable low disables memory windows, high enables them.
// - io enable low disables the io window, high enables it.
// - a sent error message sets status bit 14; write one clears.
// - parity, abort and data parity status bits read zero.
// - select timing field reads 00.
// - status bit 7 reads one.
// - status bit 5 reads one; status resets to 00A0.
//
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/1ps
module agp_bridge_command_status
  import bridge_cmd_pkg::*;
#(
  parameter int ERR_N = 4
) (
  input wire logic clk, // core clock
  input wire logic nrst, // synchronous reset, active low
  input wire logic ce, // clock enable, freezes state when low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size, word only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic [31:0] hrdata, // read data
  output logic hreadyout, // slave ready
  output logic [1:0] hresp, // always okay
  input wire logic [ERR_N-1:0] errCond, // error condition pulses
  input wire logic [ERR_N-1:0] errCondEn, // per-condition enables
  output logic errMsgSend, // one-cycle message request to hub link
  input wire logic frameStart, // AGP master frame cycle start pulse
  input wire logic frameHit, // frame address hits a decode range
  output logic frameAccept, // frame cycle claimed
  output logic frameAbort, // frame cycle left to master abort
  input wire logic sbaStart, // sideband or pipe request pulse
  output logic sbaAccept, // sideband or pipe request taken
  input wire logic memCycle, // memory cycle pulse
  input wire logic memHit, // address inside memory or prefetch window
  output logic memClaim, // memory cycle decoded
  input wire logic ioCycle, // io cycle pulse
  input wire logic ioHit, // address inside io window
  output logic ioClaim, // io cycle decoded
  output logic irq // level interrupt
);

  ////////////////////////////////////////////////////////////////////////
  logic errMsgEn_reg;
  logic busMaster_reg;
  logic memEn_reg;
  logic ioEn_reg;
  logic sysErr_reg;
  logic [IRQ_W-1:0] irqStat_reg;
  logic [IRQ_W-1:0] irqMask_reg;
  bus_state_t state_reg;
  logic wrPend_reg;
  logic [7:0] wrIdx_reg;
  logic [7:0] rdIdx_reg;
  logic addrTaken;
  logic errEvent;
  logic wrCmd;
  logic wrSts;
  logic wrIrqStat;
  logic wrIrqMask;

  function automatic logic [15:0] cmdView(input logic se, input logic bm,
                                          input logic me, input logic ie);
    logic [15:0] v;
    v = CMD_RESET;
    v[CMD_ERRMSG_BIT] = se;
    v[CMD_BM_BIT] = bm;
    v[CMD_MEM_BIT] = me;
    v[CMD_IO_BIT] = ie;
    return v;
  endfunction : cmdView

  function automatic logic [15:0] stsView(input logic system_error_signaled);
    logic [15:0] v;
    v = STS_RESET;
    v[STS_SSE_BIT] = system_error_signaled;
    return v;
  endfunction : stsView

  assign addrTaken = hsel && hready && hreadyout && (htrans == HTRANS_NONSEQ);
  assign errEvent = |(errCond & errCondEn);
  assign wrCmd = wrPend_reg && (wrIdx_reg == CMD_IDX);
  assign wrSts = wrPend_reg && (wrIdx_reg == STS_IDX);
  assign wrIrqStat = wrPend_reg && (wrIdx_reg == IRQ_STAT_IDX);
  assign wrIrqMask = wrPend_reg && (wrIdx_reg == IRQ_MASK_IDX);

  ////////////////////////////////////////////////////////////////////////
  // bus phase tracking; reads wait one cycle so a write just before lands
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_reg <= BUS_IDLE;
      wrPend_reg <= 1'b0;
      wrIdx_reg <= 8'h00;
      rdIdx_reg <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= HRESP_OKAY;
      hrdata <= 32'h0000_0000;
    end else if (ce) begin
      hresp <= HRESP_OKAY;
      unique case (state_reg)
        BUS_IDLE: begin
          wrPend_reg <= addrTaken && hwrite;
          wrIdx_reg <= haddr[9:2];
          if (addrTaken && !hwrite) begin
            state_reg <= BUS_READ;
            rdIdx_reg <= haddr[9:2];
            hreadyout <= 1'b0;
          end
        end
        BUS_READ: begin
          state_reg <= BUS_IDLE;
          wrPend_reg <= 1'b0;
          hreadyout <= 1'b1;
          // unmapped indices read zero
          unique case (rdIdx_reg)
            CMD_IDX: hrdata <= {16'h0000, cmdView(errMsgEn_reg, busMaster_reg,
                                                  memEn_reg, ioEn_reg)};
            STS_IDX: hrdata <= {16'h0000, stsView(sysErr_reg)};
            IRQ_STAT_IDX: hrdata <= {30'h0000_0000, irqStat_reg};
            IRQ_MASK_IDX: hrdata <= {30'h0000_0000, irqMask_reg};
            default: hrdata <= 32'h0000_0000;
          endcase
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // command register: only four bits hold state, the rest are constants
  always_ff @(posedge clk) begin
    if (!nrst) begin
      errMsgEn_reg <= CMD_RESET[CMD_ERRMSG_BIT];
      busMaster_reg <= CMD_RESET[CMD_BM_BIT];
      memEn_reg <= CMD_RESET[CMD_MEM_BIT];
      ioEn_reg <= CMD_RESET[CMD_IO_BIT];
    end else if (ce && wrCmd) begin
      errMsgEn_reg <= hwdata[CMD_ERRMSG_BIT];
      busMaster_reg <= hwdata[CMD_BM_BIT];
      memEn_reg <= hwdata[CMD_MEM_BIT];
      ioEn_reg <= hwdata[CMD_IO_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // error messaging; the flag sets on the message, set beats clear
  always_ff @(posedge clk) begin
    if (!nrst) begin
      errMsgSend <= 1'b0;
      sysErr_reg <= STS_RESET[STS_SSE_BIT];
    end else if (ce) begin
      errMsgSend <= errMsgEn_reg && errEvent;
      if (errMsgSend) begin
        sysErr_reg <= 1'b1;
      end else if (wrSts && hwdata[STS_SSE_BIT]) begin
        sysErr_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // cycle gating toward the AGP side
  always_ff @(posedge clk) begin
    if (!nrst) begin
      frameAccept <= 1'b0;
      frameAbort <= 1'b0;
      sbaAccept <= 1'b0;
      memClaim <= 1'b0;
      ioClaim <= 1'b0;
    end else if (ce) begin
      frameAccept <= frameStart && busMaster_reg && frameHit;
      frameAbort <= frameStart && !(busMaster_reg && frameHit);
      // sideband and pipe requests never look at the master enable
      sbaAccept <= sbaStart;
      memClaim <= memCycle && memEn_reg && memHit;
      ioClaim <= ioCycle && ioEn_reg && ioHit;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt status, mask and output
  always_ff @(posedge clk) begin
    if (!nrst) begin
      irqStat_reg <= IRQ_RESET;
      irqMask_reg <= IRQ_RESET;
      irq <= 1'b0;
    end else if (ce) begin
      // a new event in the clearing cycle survives
      irqStat_reg <= (irqStat_reg & ~(wrIrqStat ? hwdata[IRQ_W-1:0] : IRQ_RESET))
                     | ({IRQ_W{1'b0}} | (IRQ_W'(errMsgSend) << IRQ_MSG_BIT)
                     | (IRQ_W'(frameAbort) << IRQ_ABORT_BIT));
      if (wrIrqMask) begin
        irqMask_reg <= hwdata[IRQ_W-1:0];
      end
      irq <= |(irqStat_reg & irqMask_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence readReq;
    ce && addrTaken && !hwrite && (state_reg == BUS_IDLE);
  endsequence

  sequence readCmd;
    ce && (state_reg == BUS_READ) && (rdIdx_reg == CMD_IDX);
  endsequence

  sequence readSts;
    ce && (state_reg == BUS_READ) && (rdIdx_reg == STS_IDX);
  endsequence

  cmd_reset_a: assert property (disable iff (1'b0) !nrst |=>
    (cmdView(errMsgEn_reg, busMaster_reg, memEn_reg, ioEn_reg) == CMD_RESET)
    && (stsView(sysErr_reg) == STS_RESET))
    else $error("registers not at reset values");

  read_wait_a: assert property (readReq |=> !hreadyout ##1 (hreadyout == $past(ce)))
    else $error("read did not take exactly one wait state");

  cmd_zero_a: assert property (readCmd |=> ((hrdata[15:0] & CMD_ZERO_MASK) == 16'h0000))
    else $error("command constant bits not zero");

  sts_const_a: assert property (readSts |=>
    ((hrdata & {16'h0000, STS_CONST_MASK}) == {16'h0000, STS_RESET}))
    else $error("status constant bits wrong");

  msg_gate_a: assert property (ce && errEvent |=> (errMsgSend == $past(errMsgEn_reg)))
    else $error("error message not gated by enable");

  frame_abort_a: assert property (ce && frameStart && !busMaster_reg |=>
    frameAbort && !frameAccept)
    else $error("frame cycle accepted with mastering off");

  frame_accept_a: assert property (ce && frameStart && busMaster_reg && frameHit |=>
    frameAccept && !frameAbort)
    else $error("decoded frame cycle not accepted");

  sba_pass_a: assert property (ce && sbaStart |=> sbaAccept)
    else $error("sideband request blocked");

  mem_gate_a: assert property (ce && memCycle && memHit |=> (memClaim == $past(memEn_reg)))
    else $error("memory claim ignores enable");

  io_gate_a: assert property (ce && ioCycle && ioHit |=> (ioClaim == $past(ioEn_reg)))
    else $error("io claim ignores enable");

  sse_set_a: assert property (ce && errMsgSend |=> sysErr_reg ##1 (ce || sysErr_reg))
    else $error("signaled error flag not set by message");

  sse_hold_a: assert property (ce && sysErr_reg && !(wrSts && hwdata[STS_SSE_BIT])
    |=> sysErr_reg)
    else $error("signaled error flag lost without a clear");

  irq_out_a: assert property (ce && |(irqStat_reg & irqMask_reg) |=> irq)
    else $error("interrupt not raised");

  irq_low_a: assert property (ce && !(|(irqStat_reg & irqMask_reg)) |=> !irq)
    else $error("interrupt raised with nothing pending");

  // interrupt status follows the hub link message request and the AGP frame abort
  msg_stat_a: assert property (ce && errMsgSend |=> irqStat_reg[IRQ_MSG_BIT])
    else $error("message event not recorded");

  abort_stat_a: assert property (ce && frameAbort |=> irqStat_reg[IRQ_ABORT_BIT])
    else $error("abort event not recorded");

  sse_clear_a: assert property (ce && wrSts && hwdata[STS_SSE_BIT] && !errMsgSend
    |=> !sysErr_reg)
    else $error("signaled error flag not cleared by write one");

  frame_miss_a: assert property (ce && frameStart && !frameHit |=>
    frameAbort && !frameAccept)
    else $error("frame cycle outside decode ranges accepted");

  mem_miss_a: assert property (ce && memCycle && !memHit |=> !memClaim)
    else $error("memory cycle outside windows claimed");

  io_miss_a: assert property (ce && ioCycle && !ioHit |=> !ioClaim)
    else $error("io cycle outside window claimed");

  sequence cmdWrite;
    ce && wrCmd;
  endsequence

  // only the four enable bits may take written values
  cmd_write_a: assert property (cmdWrite |=>
    ({16'h0000, cmdView(errMsgEn_reg, busMaster_reg, memEn_reg, ioEn_reg)}
     == ($past(hwdata) & {16'h0000, ~CMD_ZERO_MASK})))
    else $error("command write did not land");

endmodule : agp_bridge_command_status

// File: sim/agp_master_model.sv
// Purpose: far-side model, AGP master and error sources of the bridge
// Assumes: the bench calls cyc from its own sequence, one cycle at a time
// Notes: hit levels flip after each cycle so a stale value is never seen
`timescale 1ns/1ps
module agp_master_model (
  input wire logic clk, // core clock
  output logic frameStart, // frame cycle start
  output logic frameHit, // frame decode hit
  output logic sbaStart, // sideband or pipe request
  output logic memCycle, // memory cycle
  output logic memHit, // memory window hit
  output logic ioCycle, // io cycle
  output logic ioHit, // io window hit
  output logic [3:0] errCond // error condition pulses
);
  initial begin
    {frameStart, frameHit, sbaStart, memCycle, memHit, ioCycle, ioHit} = 7'h00;
    errCond = 4'h0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // kind 0 frame, 1 sideband, 2 memory, 3 io, else error; returns when the
  // answer pulse stands
  task automatic cyc(input int kind, input logic hit);
    @(posedge clk);
    case (kind)
      0: begin frameStart <= 1'b1; frameHit <= hit; end
      1: sbaStart <= 1'b1;
      2: begin memCycle <= 1'b1; memHit <= hit; end
      3: begin ioCycle <= 1'b1; ioHit <= hit; end
      default: errCond <= 4'h1;
    endcase
    @(posedge clk);
    {frameStart, sbaStart, memCycle, ioCycle} <= 4'h0;
    errCond <= 4'h0;
    {frameHit, memHit, ioHit} <= ~{frameHit, memHit, ioHit};
    #1;
  endtask : cyc
endmodule : agp_master_model

// File: sim/agp_bridge_command_status_tb.sv
// Purpose: self-checking bench for the bridge command/status pair
// Assumes: hready tied to hreadyout, one slave on the bus
// Notes: registers sit at four times their index
`timescale 1ns/1ps
module agp_bridge_command_status_tb;
  import bridge_cmd_pkg::*;
  logic clk = 0, nrst = 0, ce = 1, hsel = 0, hwrite = 0, hreadyout, irq, errMsgSend;
  logic frameAccept, frameAbort, sbaAccept, memClaim, ioClaim;
  logic frameStart, frameHit, sbaStart, memCycle, memHit, ioCycle, ioHit;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rdv;
  logic [1:0] htrans = 0, hresp;
  logic [3:0] errCond, errCondEn = 0;
  int miscompares = 0, checked = 0;
  initial forever #5 clk = ~clk;
  agp_bridge_command_status i_agp_bridge_command_status (.clk(clk), .nrst(nrst), .ce(ce),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .errCond(errCond), .errCondEn(errCondEn), .errMsgSend(errMsgSend),
    .frameStart(frameStart), .frameHit(frameHit), .frameAccept(frameAccept),
    .frameAbort(frameAbort), .sbaStart(sbaStart), .sbaAccept(sbaAccept),
    .memCycle(memCycle), .memHit(memHit), .memClaim(memClaim), .ioCycle(ioCycle),
    .ioHit(ioHit), .ioClaim(ioClaim), .irq(irq));
  agp_master_model i_agp_master_model (.clk(clk), .frameStart(frameStart),
    .frameHit(frameHit), .sbaStart(sbaStart), .memCycle(memCycle), .memHit(memHit),
    .ioCycle(ioCycle), .ioHit(ioHit), .errCond(errCond));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      miscompares++;
    end
  endtask : chk
  // single word transfer; waits on hready, never on a fixed count
  task automatic ahb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {22'h0, idx, 2'b00};
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rdv = hrdata;
    chk("hresp", {30'h0, HRESP_OKAY}, {30'h0, hresp});
  endtask : ahb
  task automatic rd(input string what, input logic [7:0] idx, input logic [31:0] exp);
    ahb(1'b0, idx, 32'h0);
    chk(what, exp, rdv);
  endtask : rd
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd("cmd reset", CMD_IDX, 32'h0000);
    rd("sts reset", STS_IDX, 32'h00A0);
    ahb(1'b1, CMD_IDX, 32'hFFFFFFFF);
    rd("cmd ro bits", CMD_IDX, 32'h0107);
    ahb(1'b1, STS_IDX, 32'hFFFFFFFF);
    rd("sts const", STS_IDX, 32'h00A0);
    ahb(1'b1, 8'h3F, 32'hFFFFFFFF);
    rd("unmapped", 8'h3F, 32'h0000);
    $display("test regs done");
  endtask : t_regs
  task automatic t_decode();
    for (int m = 0; m < 8; m++) begin
      ahb(1'b1, CMD_IDX, 32'(m));
      i_agp_master_model.cyc(0, 1'b1);
      chk("frameAccept", 32'(m[2]), {31'h0, frameAccept});
      chk("frameAbort", 32'(!m[2]), {31'h0, frameAbort});
      i_agp_master_model.cyc(0, 1'b0);
      chk("miss abort", 32'h1, {31'h0, frameAbort});
      i_agp_master_model.cyc(1, 1'b1);
      chk("sbaAccept", 32'h1, {31'h0, sbaAccept});
      i_agp_master_model.cyc(2, 1'b1);
      chk("memClaim", 32'(m[1]), {31'h0, memClaim});
      i_agp_master_model.cyc(2, 1'b0);
      chk("mem miss", 32'h0, {31'h0, memClaim});
      i_agp_master_model.cyc(3, 1'b1);
      chk("ioClaim", 32'(m[0]), {31'h0, ioClaim});
      i_agp_master_model.cyc(3, 1'b0);
      chk("io miss", 32'h0, {31'h0, ioClaim});
    end
    $display("test decode done");
  endtask : t_decode
  task automatic t_error();
    @(posedge clk);
    errCondEn <= 4'hF;
    rd("irq abort", IRQ_STAT_IDX, 32'h2);
    ahb(1'b1, IRQ_STAT_IDX, 32'h3);
    ahb(1'b1, CMD_IDX, 32'h0000);
    i_agp_master_model.cyc(4, 1'b1);
    chk("msg off", 32'h0, {31'h0, errMsgSend});
    rd("sts no msg", STS_IDX, 32'h00A0);
    ahb(1'b1, CMD_IDX, 32'h0100);
    i_agp_master_model.cyc(4, 1'b1);
    chk("msg on", 32'h1, {31'h0, errMsgSend});
    rd("sts msg", STS_IDX, 32'h40A0);
    rd("irq stat", IRQ_STAT_IDX, 32'h1);
    chk("irq masked", 32'h0, {31'h0, irq});
    ahb(1'b1, IRQ_MASK_IDX, 32'h1);
    repeat (2) @(posedge clk);
    #1 chk("irq on", 32'h1, {31'h0, irq});
    ahb(1'b1, STS_IDX, 32'h0000);
    rd("w0 keeps", STS_IDX, 32'h40A0);
    ahb(1'b1, STS_IDX, 32'h4000);
    rd("w1 clears", STS_IDX, 32'h00A0);
    ahb(1'b1, IRQ_STAT_IDX, 32'h1);
    repeat (2) @(posedge clk);
    #1 chk("irq off", 32'h0, {31'h0, irq});
    $display("test error done");
  endtask : t_error
  // clock enable low must freeze the gating outputs as well
  task automatic t_hold();
    ahb(1'b1, CMD_IDX, 32'h0004);
    @(posedge clk);
    ce <= 1'b0;
    i_agp_master_model.cyc(0, 1'b1);
    chk("frozen accept", 32'h0, {31'h0, frameAccept});
    @(posedge clk);
    ce <= 1'b1;
    i_agp_master_model.cyc(0, 1'b1);
    chk("thawed accept", 32'h1, {31'h0, frameAccept});
    $display("test hold done");
  endtask : t_hold
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_regs();
    t_decode();
    t_error();
    t_hold();
    end_of_test();
  end
  // whole run needs well under 1500 cycles
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    end_of_test();
  end
endmodule : agp_bridge_command_status_tb
